//--- core/translation_control_pkg.sv
// Constants for the translation control register block
// Function
// - Wide-address bit selects 43-bit format when clear, 48-bit when set.
// - Wide mode: violation when address differs from sign extension of bits 47:0.
// - Narrow mode: violation when address differs from sign extension of bits 42:0.
// - Big-endian inverts the three-bit shift amount for extract, insert, mask.
// - Big-endian inverts address low bits by size: byte 2:0, word 2:1, long 2.
// - Format control holds page table base 63:30; view builds entry address.
// - Bit 2 selects the 32-bit layout of the page-entry view.
// - Tag staging write only updates a holding register, not the array.
// - Retired page-entry write stores staged tag and entry into one slot.
// - Fill slots chosen round-robin; first fill after reset goes to slot 0.
// - Flush-process write invalidates entries with match-all bit clear only.
// - Flush-all write invalidates all entries and resets the fill pointer.
// - Flush-single invalidates page match 47:13, minus the low bits masked by the entry's hint, with space number match.
// - Flush-single also invalidates page matches whose match-all bit is set.
// - Flush-single never requests an instruction cache flush.
// - Exception return address loads on every exception; bit 0 marks firmware mode.
// - Fault or synchronous trap captures the faulting instruction address.
// - Interrupt captures the address of the next instruction to execute.
// - Data miss or fault latches fault address, except for page-entry loads.
package translation_control_pkg;
	localparam int WIDE_ADDR_MSB = 47;
	localparam int NARROW_ADDR_MSB = 42;
	localparam int BASE_LSB = 30;
	localparam int NARROW_FORMAT_BIT = 2;
	localparam int WIDE_SELECT_BIT = 1;
	localparam int BIG_ENDIAN_BIT = 0;
	localparam int PAGE_LSB = 13;
	localparam int PAGE_MSB = 47;
	localparam int SPACE_LSB = 39;
	localparam int SPACE_MSB = 46;
	localparam int ENTRY_SHIFT = 3;
	localparam int TLB_ENTRIES = 16;
	localparam int MATCH_ALL_BIT = 4;
	localparam int HINT_LSB = 5;
	localparam logic [63:0] CTRL_RESET = 64'h0000000000000000;
	typedef enum logic [1:0] {
		SIZE_BYTE,
		SIZE_WORD,
		SIZE_LONG,
		SIZE_QUAD
	} ref_size_t;
	typedef enum logic [2:0] {
		REG_NONE,
		REG_FORMAT_CTRL,
		REG_TAG_STAGING,
		REG_ENTRY_COMMIT,
		REG_FLUSH_PROCESS,
		REG_FLUSH_ALL,
		REG_FLUSH_SINGLE
	} reg_sel_t;
	typedef enum logic [1:0] {
		EXC_NONE,
		EXC_FAULT,
		EXC_INTERRUPT
	} exc_kind_t;
endpackage

//--- core/translation_control_regs.sv
// Translation control registers, instruction TLB staging/fill/invalidate and exception capture
`timescale 1ns/1ps
module translation_control_regs #(
	parameter int ENTRIES = translation_control_pkg::TLB_ENTRIES,
	parameter int GH_BITS = 2
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic wrEn,
	input wire translation_control_pkg::reg_sel_t wrSel,
	input wire logic wrRetire,
	input wire logic [63:0] wrData,
	input wire logic [7:0] processContextAsn,
	output logic [63:0] pageEntryAddressView,
	output logic [63:0] exceptionReturnPc,
	output logic [63:0] faultAddressCapture,
	output logic narrowFormatSelect,
	output logic wideAddressSelect,
	output logic bigEndian,
	input wire logic [63:0] effAddr,
	output logic accessViolation,
	input wire logic [2:0] shiftIn,
	output logic [2:0] shiftOut,
	input wire logic [2:0] paLowIn,
	input wire translation_control_pkg::ref_size_t refSize,
	output logic [2:0] paLowOut,
	input wire logic dataFault,
	input wire logic [63:0] dataFaultVa,
	input wire logic pageEntryLoadOp,
	input wire translation_control_pkg::exc_kind_t excKind,
	input wire logic [63:0] faultPc,
	input wire logic [63:0] nextPc,
	input wire logic privilegedFirmwareMode,
	input wire logic [63:13] lookupPage,
	output logic lookupHit,
	output logic [63:0] lookupEntry,
	output logic [ENTRIES-1:0] entryValid,
	output logic icacheFlushAll,
	output logic icacheFlushPerProcess
);
	localparam int PW = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;
	// Entries keep tag bits 63:13 only; the low bits of a staged tag are page offset
	localparam int PMSB = translation_control_pkg::PAGE_MSB;
	localparam int PLSB = translation_control_pkg::PAGE_LSB;

	////////////////////////////////////////////////////////////////////////////
	// Format control register

	logic [63:30] baseQ;
	logic narrowQ;
	logic wideQ;
	logic endianQ;
	logic ctrlWr;

	assign ctrlWr = wrEn && wrSel == translation_control_pkg::REG_FORMAT_CTRL;

	// Only the base and the three control bits are kept; the reserved middle of
	// the word is dropped on write and reads back nowhere
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			baseQ <= translation_control_pkg::CTRL_RESET[63:30];
		end else if (ctrlWr) begin
			baseQ <= wrData[63:30];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			narrowQ <= 1'b0;
			wideQ <= 1'b0;
			endianQ <= 1'b0;
		end else if (ctrlWr) begin
			narrowQ <= wrData[translation_control_pkg::NARROW_FORMAT_BIT];
			wideQ <= wrData[translation_control_pkg::WIDE_SELECT_BIT];
			endianQ <= wrData[translation_control_pkg::BIG_ENDIAN_BIT];
		end
	end

	assign narrowFormatSelect = narrowQ;
	assign wideAddressSelect = wideQ;
	assign bigEndian = endianQ;

	////////////////////////////////////////////////////////////////////////////
	// Sign checker

	localparam int WMSB = translation_control_pkg::WIDE_ADDR_MSB;
	localparam int NMSB = translation_control_pkg::NARROW_ADDR_MSB;

	logic [63:0] sext48;
	logic [63:0] sext43;
	logic wideBad;
	logic narrowBad;

	// Both formats are checked every cycle so the select bit only steers a mux and
	// a control write cannot leave a stale check result behind
	assign sext48 = {{(63 - WMSB){effAddr[WMSB]}}, effAddr[WMSB:0]};
	assign sext43 = {{(63 - NMSB){effAddr[NMSB]}}, effAddr[NMSB:0]};
	assign wideBad = effAddr != sext48;
	assign narrowBad = effAddr != sext43;
	assign accessViolation = wideQ ? wideBad : narrowBad;

	////////////////////////////////////////////////////////////////////////////
	// Endian inversion

	logic [2:0] sizeFlip;

	assign shiftOut = endianQ ? ~shiftIn : shiftIn;

	// Quadword references keep their address, only shorter ones are mirrored
	always_comb begin
		sizeFlip = 3'h0;
		if (endianQ) begin
			case (refSize)
				translation_control_pkg::SIZE_BYTE: sizeFlip = 3'h7;
				translation_control_pkg::SIZE_WORD: sizeFlip = 3'h6;
				translation_control_pkg::SIZE_LONG: sizeFlip = 3'h4;
				translation_control_pkg::SIZE_QUAD: sizeFlip = 3'h0;
				default: sizeFlip = 3'h0;
			endcase
		end
	end

	assign paLowOut = paLowIn ^ sizeFlip;

	////////////////////////////////////////////////////////////////////////////
	// Fault address capture

	logic [63:0] faultQ;
	logic faultTake;

	// A miss on the page-entry load itself must not overwrite the address that
	// the handler is still working on
	assign faultTake = dataFault && !pageEntryLoadOp;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			faultQ <= 64'h0000000000000000;
		end else if (faultTake) begin
			faultQ <= dataFaultVa;
		end
	end

	assign faultAddressCapture = faultQ;

	////////////////////////////////////////////////////////////////////////////
	// Page-entry view

	logic [63:0] viewNarrow;
	logic [63:0] viewWide;
	logic [63:0] viewBase;

	// All three layouts end in three zero bits so the result is entry aligned
	assign viewNarrow = {baseQ, 8'h00, faultQ[31:13], 3'h0};
	assign viewWide = {baseQ[63:38], faultQ[47:13], 3'h0};
	assign viewBase = {baseQ[63:33], faultQ[42:13], 3'h0};

	// The view is combinational from stored state so it tracks control writes at once
	always_comb begin
		pageEntryAddressView = viewBase;
		if (narrowQ) begin
			pageEntryAddressView = viewNarrow;
		end else if (wideQ) begin
			pageEntryAddressView = viewWide;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Exception return address

	logic excTake;
	logic [63:0] excPc;
	logic [63:0] excAddrD;

	// Faults report the culprit, interrupts the instruction that was about to run
	always_comb begin
		excTake = 1'b0;
		excPc = faultPc;
		case (excKind)
			translation_control_pkg::EXC_FAULT: begin
				excTake = 1'b1;
				excPc = faultPc;
			end
			translation_control_pkg::EXC_INTERRUPT: begin
				excTake = 1'b1;
				excPc = nextPc;
			end
			default: begin
				excTake = 1'b0;
				excPc = faultPc;
			end
		endcase
	end

	// Bit 0 of a pc is always zero, so it is free to carry the firmware mode flag
	assign excAddrD = {excPc[63:1], privilegedFirmwareMode};

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			exceptionReturnPc <= 64'h0000000000000000;
		end else if (excTake) begin
			exceptionReturnPc <= excAddrD;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Instruction TLB staging, fill and invalidate

	logic [63:0] tagStageQ;
	logic [PW-1:0] fillPtrQ;
	logic [PW-1:0] fillPtrD;
	logic [63:13] tagQ [ENTRIES];
	logic [63:0] pteQ [ENTRIES];
	logic [7:0] asnQ [ENTRIES];
	logic [ENTRIES-1:0] validQ;
	logic commit;
	logic flushProc;
	logic flushAll;
	logic flushOne;
	logic tagWr;

	assign commit = wrRetire && wrSel == translation_control_pkg::REG_ENTRY_COMMIT;
	assign flushProc = wrEn && wrSel == translation_control_pkg::REG_FLUSH_PROCESS;
	assign flushAll = wrEn && wrSel == translation_control_pkg::REG_FLUSH_ALL;
	assign flushOne = wrEn && wrSel == translation_control_pkg::REG_FLUSH_SINGLE;
	assign tagWr = wrEn && wrSel == translation_control_pkg::REG_TAG_STAGING;

	// Staging never touches the array, so a tag write on its own changes no lookup
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tagStageQ <= 64'h0000000000000000;
		end else if (tagWr) begin
			tagStageQ <= wrData;
		end
	end

	// The pointer wraps by compare rather than by overflow so any entry count works
	always_comb begin
		fillPtrD = fillPtrQ;
		if (flushAll) begin
			fillPtrD = '0;
		end else if (commit) begin
			if (fillPtrQ == PW'(ENTRIES - 1)) begin
				fillPtrD = '0;
			end else begin
				fillPtrD = fillPtrQ + 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fillPtrQ <= '0;
		end else begin
			fillPtrQ <= fillPtrD;
		end
	end

	always_ff @(posedge clk) begin
		if (commit) begin
			tagQ[fillPtrQ] <= tagStageQ[63:13];
			pteQ[fillPtrQ] <= wrData;
			asnQ[fillPtrQ] <= processContextAsn;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Per-entry match terms

	// Stored fields are unknown until a slot is first filled, so every kill and hit
	// term is gated by the valid bit and a never-filled slot stays quiet
	logic [ENTRIES-1:0] globalEntry;
	logic [ENTRIES-1:0] spaceMatch;
	logic [ENTRIES-1:0] spaceOk;
	logic [ENTRIES-1:0] flushPageHit;
	logic [ENTRIES-1:0] lookupPageHit;
	logic [ENTRIES-1:0] killProc;
	logic [ENTRIES-1:0] killSingle;
	logic [ENTRIES-1:0] fillHere;
	logic [ENTRIES-1:0] entryHit;

	for (genvar g = 0; g < ENTRIES; g++) begin : gen_entry
		logic [GH_BITS-1:0] hint;
		logic [34:0] pageMask;
		logic [34:0] storedPage;
		logic [34:0] flushPage;
		logic [34:0] probePage;

		assign hint = pteQ[g][translation_control_pkg::HINT_LSB +: GH_BITS];
		// Each hint step makes the page eight times larger, so three more low bits drop
		assign pageMask = {35{1'b1}} << (3 * hint);
		assign storedPage = tagQ[g][PMSB:PLSB];
		assign flushPage = wrData[PMSB:PLSB];
		assign probePage = lookupPage[PMSB:PLSB];
		assign globalEntry[g] = pteQ[g][translation_control_pkg::MATCH_ALL_BIT];
		assign spaceMatch[g] = asnQ[g] == processContextAsn;
		assign spaceOk[g] = globalEntry[g] || spaceMatch[g];
		assign flushPageHit[g] = ((storedPage ^ flushPage) & pageMask) == 35'h000000000;
		assign lookupPageHit[g] = storedPage == probePage;
		// Global entries survive a process flush
		assign killProc[g] = validQ[g] && !globalEntry[g];
		assign killSingle[g] = validQ[g] && flushPageHit[g] && spaceOk[g];
		assign fillHere[g] = commit && fillPtrQ == PW'(g);
		assign entryHit[g] = validQ[g] && lookupPageHit[g] && spaceOk[g];
	end

	// Flushes and fills never meet, since each decodes its own wrSel value
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			validQ <= '0;
		end else if (flushAll) begin
			validQ <= '0;
		end else if (flushProc) begin
			validQ <= validQ & ~killProc;
		end else if (flushOne) begin
			validQ <= validQ & ~killSingle;
		end else if (commit) begin
			validQ <= validQ | fillHere;
		end
	end

	assign entryValid = validQ;

	////////////////////////////////////////////////////////////////////////////
	// Lookup

	// Last matching slot wins; software must not load two overlapping live entries
	always_comb begin
		lookupHit = |entryHit;
		lookupEntry = 64'h0000000000000000;
		for (int i = 0; i < ENTRIES; i++) begin
			if (entryHit[i]) begin
				lookupEntry = pteQ[i];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Instruction cache flush requests

	// Cache flush requests are tied low, raised by no command and never by TLB flushes;
	// the cache is virtually tagged, so paging needs no flush of it
	assign icacheFlushAll = 1'b0;
	assign icacheFlushPerProcess = 1'b0;
endmodule

//--- verif/tb.sv
// Self-checking testbench for the translation control register block
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin mismatches++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
logic clk = 0, nrst = 0, wrEn = 0, wrRetire = 0, dataFault = 0, pageEntryLoadOp = 0;
logic privilegedFirmwareMode = 0;
logic [63:0] wrData = 0, effAddr = 0, dataFaultVa = 0, faultPc = 0, nextPc = 0;
logic [7:0] processContextAsn = 8'h11;
logic [2:0] shiftIn = 0, paLowIn = 0;
logic [63:13] lookupPage = 0;
translation_control_pkg::reg_sel_t wrSel = translation_control_pkg::REG_NONE;
translation_control_pkg::ref_size_t refSize = translation_control_pkg::SIZE_BYTE;
translation_control_pkg::exc_kind_t excKind = translation_control_pkg::EXC_NONE;
logic narrowFormatSelect, wideAddressSelect, bigEndian, accessViolation, lookupHit;
logic icacheFlushAll, icacheFlushPerProcess;
logic [63:0] pageEntryAddressView, exceptionReturnPc, faultAddressCapture, lookupEntry;
logic [2:0] shiftOut, paLowOut;
logic [15:0] entryValid;
int mismatches = 0, n_compared = 0, cyc = 0;
translation_control_regs dut (.*);
always #2.5 clk = ~clk;
////////////////////////////////////////////////////////////////
task automatic wrap_up;
	$display("compared %0d, mismatches %0d", n_compared, mismatches);
	if (mismatches == 0 && n_compared > 0)
		$display("*** PASS ***");
	else
		$display("*** FAIL ***");
	$finish;
endtask
always @(posedge clk) begin
	cyc++;
	if (cyc == 3000) begin
		mismatches++;
		wrap_up;
	end
end
task automatic wr(input translation_control_pkg::reg_sel_t s, input logic [63:0] d,
	input logic r = 1'b0);
	@(negedge clk);
	wrSel = s;
	wrData = d;
	wrEn = !r;
	wrRetire = r;
	@(negedge clk);
	wrEn = 0;
	wrRetire = 0;
endtask
task automatic fill(input logic [63:0] tag, input logic [63:0] ent);
	wr(translation_control_pkg::REG_TAG_STAGING, tag, 0);
	wr(translation_control_pkg::REG_ENTRY_COMMIT, ent, 1);
endtask
////////////////////////////////////////////////////////////////
task automatic t_format;
	logic [63:0] b = 64'hfedc_ba98_c000_0000;
	logic [63:0] v = 64'h0000_1234_5678_9abc;
	`CHK({narrowFormatSelect, wideAddressSelect, bigEndian, entryValid}, 19'h0)
	@(negedge clk);
	dataFault = 1;
	dataFaultVa = v;
	@(negedge clk);
	pageEntryLoadOp = 1;
	dataFaultVa = 64'h55;
	@(negedge clk);
	dataFault = 0;
	`CHK(faultAddressCapture, v)
	wr(translation_control_pkg::REG_FORMAT_CTRL, b | 64'h4);
	`CHK(pageEntryAddressView, {b[63:30], 8'h0, v[31:13], 3'h0})
	wr(translation_control_pkg::REG_FORMAT_CTRL, b);
	`CHK(pageEntryAddressView, {b[63:33], v[42:13], 3'h0})
	effAddr = 64'h0000_0400_0000_0000;
	#1;
	`CHK(accessViolation, 1'b1)
	wr(translation_control_pkg::REG_FORMAT_CTRL, 64'h2);
	`CHK({wideAddressSelect, accessViolation}, 2'h2)
	`CHK(pageEntryAddressView, {26'h0, v[47:13], 3'h0})
endtask
task automatic t_endian;
	logic [2:0] m[4] = '{3'h7, 3'h6, 3'h4, 3'h0};
	wr(translation_control_pkg::REG_FORMAT_CTRL, 64'h1);
	for (int i = 0; i < 4; i++) begin
		refSize = translation_control_pkg::ref_size_t'(i);
		shiftIn = 3'(i);
		paLowIn = 3'h5;
		#1;
		`CHK(shiftOut, ~3'(i))
		`CHK(paLowOut, 3'h5 ^ m[i])
	end
endtask
task automatic t_fill;
	fill(64'h2000, 64'h0);
	`CHK(entryValid, 16'h1)
	wr(translation_control_pkg::REG_TAG_STAGING, 64'h6000, 0);
	`CHK(entryValid, 16'h1)
	fill(64'h4000, 64'h10);
	wr(translation_control_pkg::REG_FLUSH_PROCESS, 64'h0, 0);
	`CHK(entryValid, 16'h2)
	wr(translation_control_pkg::REG_FLUSH_ALL, 64'h0, 0);
	fill(64'h2000, 64'h0);
	fill(64'h4000, 64'h10);
	`CHK(entryValid, 16'h3)
	lookupPage = 51'h2;
	#1;
	`CHK({lookupHit, lookupEntry}, {1'b1, 64'h10})
	processContextAsn = 8'h22;
	wr(translation_control_pkg::REG_FLUSH_SINGLE, 64'h2000, 0);
	`CHK(entryValid, 16'h3)
	wr(translation_control_pkg::REG_FLUSH_SINGLE, 64'h4000, 0);
	`CHK(entryValid, 16'h1)
	processContextAsn = 8'h11;
	wr(translation_control_pkg::REG_FLUSH_SINGLE, 64'h2000, 0);
	`CHK({entryValid, icacheFlushAll, icacheFlushPerProcess}, 18'h0)
endtask
task automatic t_exc;
	@(negedge clk);
	excKind = translation_control_pkg::EXC_FAULT;
	faultPc = 64'h1000_0010;
	privilegedFirmwareMode = 1;
	@(negedge clk);
	excKind = translation_control_pkg::EXC_INTERRUPT;
	nextPc = 64'h2000_0024;
	privilegedFirmwareMode = 0;
	`CHK(exceptionReturnPc, 64'h1000_0011)
	@(negedge clk);
	excKind = translation_control_pkg::EXC_NONE;
	`CHK(exceptionReturnPc, 64'h2000_0024)
endtask
initial begin
	repeat (2) @(negedge clk);
	nrst = 1;
	t_format;
	t_endian;
	t_fill;
	t_exc;
	wrap_up;
end
endmodule

//--- verif/translation_control_chk.sv
// Assertion checker for the translation control register block
`timescale 1ns/1ps
module translation_control_chk #(
	parameter int ENTRIES = 16
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic wrEn,
	input wire translation_control_pkg::reg_sel_t wrSel,
	input wire logic wrRetire,
	input wire logic [63:0] effAddr,
	input wire logic accessViolation,
	input wire logic wideAddressSelect,
	input wire logic bigEndian,
	input wire logic [2:0] shiftIn,
	input wire logic [2:0] shiftOut,
	input wire logic dataFault,
	input wire logic [63:0] dataFaultVa,
	input wire logic pageEntryLoadOp,
	input wire logic [63:0] faultAddressCapture,
	input wire translation_control_pkg::exc_kind_t excKind,
	input wire logic [63:0] faultPc,
	input wire logic [63:0] nextPc,
	input wire logic privilegedFirmwareMode,
	input wire logic [63:0] exceptionReturnPc,
	input wire logic [ENTRIES-1:0] entryValid,
	input wire logic icacheFlushAll,
	input wire logic icacheFlushPerProcess
);
default clocking @(posedge clk); endclocking
default disable iff (!nrst);
////////////////////////////////////////////////////////////////
sequence commitSeq;
	wrRetire && !wrEn && wrSel == translation_control_pkg::REG_ENTRY_COMMIT;
endsequence
sequence flushAllSeq;
	wrEn && wrSel == translation_control_pkg::REG_FLUSH_ALL;
endsequence
AST_WIDE_SIGN: assert property (wideAddressSelect |->
	accessViolation == (effAddr != {{16{effAddr[47]}}, effAddr[47:0]})) else $error("wide sign");
AST_NARROW_SIGN: assert property (!wideAddressSelect |->
	accessViolation == (effAddr != {{21{effAddr[42]}}, effAddr[42:0]})) else $error("narrow sign");
AST_SHIFT: assert property (shiftOut == (bigEndian ? ~shiftIn : shiftIn))
	else $error("shift inversion");
AST_FAULT_CAP: assert property (dataFault && !pageEntryLoadOp |=>
	faultAddressCapture == $past(dataFaultVa)) else $error("fault capture");
AST_LOAD_OP: assert property (dataFault && pageEntryLoadOp |=> $stable(faultAddressCapture))
	else $error("page-entry load captured");
AST_EXC_FAULT: assert property (excKind == translation_control_pkg::EXC_FAULT |=>
	exceptionReturnPc == {$past(faultPc[63:1]), $past(privilegedFirmwareMode)}) else $error("fault pc");
AST_EXC_INT: assert property (excKind == translation_control_pkg::EXC_INTERRUPT |=>
	exceptionReturnPc == {$past(nextPc[63:1]), $past(privilegedFirmwareMode)}) else $error("int pc");
AST_FLUSH_ALL: assert property (flushAllSeq |=> entryValid == '0) else $error("flush all");
AST_FILL: assert property (commitSeq |=> entryValid != '0) else $error("fill lost");
AST_NO_ICACHE: assert property (!icacheFlushAll && !icacheFlushPerProcess)
	else $error("icache flush raised");
endmodule
bind translation_control_regs translation_control_chk #(.ENTRIES(ENTRIES)) chk (.*);
